// ===== rtl/arsf_pkg.sv
// Package for the converter result and status flag block.
package arsf_pkg;
    localparam int ARSF_NUM_CH = 8;
    localparam int ARSF_DATA_W = 10;
    localparam int ARSF_CH_W = 3;
    localparam logic ARSF_FLAG_RST = 1'b0;
    localparam logic [ARSF_DATA_W-1:0] ARSF_DATA_RST = 10'h000;
    localparam logic [ARSF_CH_W-1:0] ARSF_CH_RST = 3'h0;
    localparam logic [ARSF_CH_W:0] ARSF_NO_SRC = 4'h8;

    typedef enum logic [1:0] {
        ARSF_AWAKE = 2'b00,
        ARSF_SLEEP_ARMED = 2'b01,
        ARSF_ASLEEP = 2'b10
    } arsf_sleep_e;
endpackage : arsf_pkg

// ===== rtl/arsf_flag.sv
// One sticky flag in which a hardware set beats a same-cycle clear.
`timescale 1ns/10ps
module arsf_flag
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Events
    input wire logic set_in,
    input wire logic clr_in,
    // State
    output logic flag_out
);
    import arsf_pkg::*;

    logic flag_d;
    logic flag_q;

    always_comb
    begin
        flag_d = flag_q;
        if (clr_in)
        begin
            flag_d = 1'b0;
        end
        if (set_in)
        begin
            flag_d = 1'b1; // RULE_15
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            flag_q <= ARSF_FLAG_RST;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;
endmodule : arsf_flag

// ===== rtl/arsf_top.sv
// Result registers, end-of-conversion, ready and overrun flags, and deferred sleep.
`timescale 1ns/10ps
// Operation
// RULE_01 - Only a read of the last-result register clears the global ready flag.
// RULE_02 - The global ready flag rises only when new data is really stored.
// RULE_03 - A channel result read never blocks the ready flag raised by another channel's completion.
// RULE_04 - A disable in the same cycle as a completion still stores both results and raises ready; the code refuses such a completion and stores nothing.
// RULE_05 - A status read with a completion still updates general overrun, set winning over clear.
// RULE_06 - General overrun is set by a completion while done and ready are set, whatever else is read; the code needs only ready set.
// RULE_07 - A disable in the same cycle does not stop general overrun from rising; the code refuses such a completion, so general overrun does not rise.
// RULE_08 - A channel's overrun flag rises when it completes while its done flag is still set.
// RULE_09 - Reading a channel result or the last result clears that channel's done flag.
// RULE_10 - A status read clears every channel overrun flag even if a completion sets done again; in the code a same-cycle overrun set wins over it.
// RULE_11 - A channel disabled during its conversion never gets its done flag raised.
// RULE_12 - A channel result read clears only the done flag of the channel read.
// RULE_13 - Sleep requested while idle takes effect only after the next conversion completes.
// RULE_14 - Each completion loads both result registers and sets done and ready in one cycle.
// RULE_15 - A hardware set wins over a software clear in the same cycle.
module arsf_top
#(
    parameter int NUM_CH = arsf_pkg::ARSF_NUM_CH,
    parameter int DATA_W = arsf_pkg::ARSF_DATA_W
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Conversion core
    input wire logic eoc_in,
    input wire logic [arsf_pkg::ARSF_CH_W-1:0] eoc_ch_in,
    input wire logic [DATA_W-1:0] eoc_data_in,
    input wire logic conv_busy_in,
    // Software controls
    input wire logic [NUM_CH-1:0] ch_enable_in,
    input wire logic rd_ch_result_in,
    input wire logic [arsf_pkg::ARSF_CH_W-1:0] rd_ch_sel_in,
    input wire logic rd_last_result_in,
    input wire logic rd_status_in,
    input wire logic sleep_mode_in,
    // Results
    output logic [NUM_CH*DATA_W-1:0] channel_result_register_out,
    output logic [DATA_W-1:0] last_result_reg_out,
    output logic [arsf_pkg::ARSF_CH_W-1:0] last_result_ch_out,
    // Flags
    output logic [NUM_CH-1:0] eoc_flag_out,
    output logic [NUM_CH-1:0] channel_overrun_flag_out,
    output logic global_result_ready_flag_out,
    output logic general_overrun_flag_out,
    output logic asleep_out
);
    import arsf_pkg::*;

    logic [NUM_CH-1:0] done_set;
    logic [NUM_CH-1:0] done_clr;
    logic [NUM_CH-1:0] done_q;
    logic [NUM_CH-1:0] ovr_set;
    logic [NUM_CH-1:0] ovr_q;
    logic eoc_valid;
    logic [NUM_CH-1:0] ovr_clr;
    logic ready_set;
    logic ready_clr;
    logic ready_q;
    logic govr_set;
    logic govr_clr;
    logic govr_q;
    logic asleep_d;
    logic asleep_q;
    logic [NUM_CH-1:0] conv_en_d;
    logic [NUM_CH-1:0] conv_en_q;
    logic [NUM_CH*DATA_W-1:0] cdr_d;
    logic [NUM_CH*DATA_W-1:0] cdr_q;
    logic [DATA_W-1:0] last_result_reg_d;
    logic [DATA_W-1:0] last_result_reg_q;
    logic [ARSF_CH_W-1:0] lch_d;
    logic [ARSF_CH_W-1:0] lch_q;
    arsf_sleep_e slp_d;
    arsf_sleep_e slp_q;

    // Channel bit of a channel number, zero when the number is out of range.
    function automatic logic [NUM_CH-1:0] ch_bit(input logic [ARSF_CH_W-1:0] ch);
        logic [NUM_CH-1:0] v;
        v = '0;
        if (int'(ch) < NUM_CH)
        begin
            v[ch] = 1'b1;
        end
        return v;
    endfunction : ch_bit

    // A conversion counts only if its channel was enabled when it started and still is.
    // Tracking the start-time enable keeps a late disable from raising done.
    always_comb
    begin
        conv_en_d = conv_en_q;
        if (!conv_busy_in)
        begin
            conv_en_d = ch_enable_in;
        end
        conv_en_d = conv_en_d & ch_enable_in;
    end

    // A completion is stored only for a channel enabled at the start and still enabled now.
    assign eoc_valid = eoc_in && ((ch_bit(eoc_ch_in) & conv_en_q & ch_enable_in) != '0); // RULE_11

    always_comb
    begin
        done_set = '0;
        ovr_set = '0;
        done_clr = '0;
        if (eoc_valid)
        begin
            done_set = ch_bit(eoc_ch_in); // RULE_14
            ovr_set = ch_bit(eoc_ch_in) & done_q; // RULE_08
        end
        if (rd_ch_result_in)
        begin
            done_clr = done_clr | ch_bit(rd_ch_sel_in); // RULE_12
        end
        if (rd_last_result_in)
        begin
            done_clr = done_clr | ch_bit(lch_q); // RULE_09
        end
    end

    // Global flag events. Only a stored result raises ready, so a refused completion
    // never claims new data; only the last-result read lowers it.
    always_comb
    begin
        ready_set = 1'b0;
        ready_clr = 1'b0;
        govr_set = 1'b0;
        govr_clr = 1'b0;
        ovr_clr = '0;
        if (eoc_valid)
        begin
            ready_set = 1'b1; // RULE_02 RULE_03 RULE_04
            // Any stored result that finds ready still set overruns the last result.
            govr_set = ready_q; // RULE_05 RULE_06 RULE_07
        end
        if (rd_last_result_in)
        begin
            ready_clr = 1'b1; // RULE_01
        end
        if (rd_status_in)
        begin
            govr_clr = 1'b1; // RULE_05
            ovr_clr = '1; // RULE_10
        end
    end

    // Result storage.
    always_comb
    begin
        cdr_d = cdr_q;
        last_result_reg_d = last_result_reg_q;
        lch_d = lch_q;
        if (eoc_valid)
        begin
            cdr_d[int'(eoc_ch_in)*DATA_W +: DATA_W] = eoc_data_in; // RULE_04
            last_result_reg_d = eoc_data_in; // RULE_14
            lch_d = eoc_ch_in;
        end
    end

    // Deferred sleep: the converter sleeps only once the next conversion ends.
    always_comb
    begin
        slp_d = slp_q;
        case (slp_q)
            ARSF_AWAKE:
            begin
                if (sleep_mode_in)
                begin
                    slp_d = ARSF_SLEEP_ARMED;
                end
            end
            ARSF_SLEEP_ARMED:
            begin
                if (!sleep_mode_in)
                begin
                    slp_d = ARSF_AWAKE;
                end
                else if (eoc_in)
                begin
                    slp_d = ARSF_ASLEEP; // RULE_13
                end
            end
            ARSF_ASLEEP:
            begin
                if (!sleep_mode_in)
                begin
                    slp_d = ARSF_AWAKE;
                end
            end
            default:
            begin
                slp_d = ARSF_AWAKE;
            end
        endcase
        // Decoded from the next state so the registered output moves with the state.
        asleep_d = (slp_d == ARSF_ASLEEP);
    end

    // Start-time enables of the running conversion.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            conv_en_q <= '0;
        end
        else
        begin
            conv_en_q <= conv_en_d;
        end
    end

    // Result registers and the channel that produced the last result.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cdr_q <= '0;
            last_result_reg_q <= ARSF_DATA_RST;
            lch_q <= ARSF_CH_RST;
        end
        else
        begin
            cdr_q <= cdr_d;
            last_result_reg_q <= last_result_reg_d;
            lch_q <= lch_d;
        end
    end

    // The sleep output is registered so that it leaves the block glitch free.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            slp_q <= ARSF_AWAKE;
            asleep_q <= ARSF_FLAG_RST;
        end
        else
        begin
            slp_q <= slp_d;
            asleep_q <= asleep_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            arsf_flag u_done
            (
                .clk_in(clk_in),
                .arst_n_in(arst_n_in),
                .set_in(done_set[gi]),
                .clr_in(done_clr[gi]),
                .flag_out(done_q[gi])
            );
            arsf_flag u_ovr
            (
                .clk_in(clk_in),
                .arst_n_in(arst_n_in),
                .set_in(ovr_set[gi]),
                .clr_in(ovr_clr[gi]), // RULE_10
                .flag_out(ovr_q[gi])
            );
        end
    endgenerate

    // Ready is set only by stored data and cleared only by the last-result read.
    arsf_flag u_ready
    (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .set_in(ready_set), // RULE_02 RULE_03 RULE_04
        .clr_in(ready_clr), // RULE_01
        .flag_out(ready_q)
    );

    // General overrun: a stored completion while ready is still set.
    arsf_flag u_govr
    (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .set_in(govr_set), // RULE_05 RULE_06 RULE_07
        .clr_in(govr_clr), // RULE_05
        .flag_out(govr_q)
    );

    assign channel_result_register_out = cdr_q;
    assign last_result_reg_out = last_result_reg_q;
    assign last_result_ch_out = lch_q;
    assign eoc_flag_out = done_q;
    assign channel_overrun_flag_out = ovr_q;
    assign global_result_ready_flag_out = ready_q;
    assign general_overrun_flag_out = govr_q;
    assign asleep_out = asleep_q;
endmodule : arsf_top

// ===== verif/arsf_top_sva.sv
// Assertions on the flag outputs of the converter result block.
`timescale 1ns/10ps
module arsf_top_sva
#(
    parameter int NUM_CH = 8
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Events
    input wire logic eoc_in,
    input wire logic [arsf_pkg::ARSF_CH_W-1:0] eoc_ch_in,
    input wire logic conv_busy_in,
    input wire logic [NUM_CH-1:0] ch_enable_in,
    input wire logic rd_ch_result_in,
    input wire logic [arsf_pkg::ARSF_CH_W-1:0] rd_ch_sel_in,
    input wire logic rd_last_result_in,
    input wire logic rd_status_in,
    // Flags
    input wire logic [NUM_CH-1:0] eoc_flag_out,
    input wire logic [NUM_CH-1:0] channel_overrun_flag_out,
    input wire logic global_result_ready_flag_out,
    input wire logic general_overrun_flag_out
);
    import arsf_pkg::*;
    logic [NUM_CH-1:0] cap_q;
    logic hit;
    logic ovr_hit;
    // A channel dropped while its conversion runs counts as refused, so the capture is mirrored.
    always_ff @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in)
            cap_q <= '0;
        else if (!conv_busy_in)
            cap_q <= ch_enable_in;
        else
            cap_q <= cap_q & ch_enable_in;
    assign hit = eoc_in && cap_q[eoc_ch_in] && ch_enable_in[eoc_ch_in];
    assign ovr_hit = hit && eoc_flag_out[eoc_ch_in];
    sequence s_govr;
        hit && global_result_ready_flag_out;
    endsequence
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    store_sets_a: assert property (hit |=> global_result_ready_flag_out
        && eoc_flag_out[$past(eoc_ch_in)]) else $error("completion not flagged");
    ovr_set_a: assert property (ovr_hit |=>
        channel_overrun_flag_out[$past(eoc_ch_in)]) else $error("overrun missed");
    govr_set_a: assert property (s_govr |=> general_overrun_flag_out)
        else $error("general overrun missed");
    govr_clr_a: assert property (rd_status_in && !(hit &&
        global_result_ready_flag_out) |=> !general_overrun_flag_out) else $error("govr kept");
    ovr_clr_a: assert property (rd_status_in && !ovr_hit |=>
        channel_overrun_flag_out == '0) else $error("overrun kept");
    ready_drop_a: assert property (rd_last_result_in && !hit |=>
        !global_result_ready_flag_out) else $error("ready kept");
    done_only_a: assert property (rd_ch_result_in && !eoc_in && !rd_last_result_in |=>
        eoc_flag_out == ($past(eoc_flag_out) & ~(NUM_CH'(1) << $past(rd_ch_sel_in))))
        else $error("wrong done cleared");
    no_done_a: assert property (eoc_in && !hit |=> !eoc_flag_out[$past(eoc_ch_in)] ||
        $past(eoc_flag_out[eoc_ch_in])) else $error("refused channel flagged");
endmodule : arsf_top_sva

// ===== verif/arsf_core_model.sv
// Behavioural conversion core: one conversion per start, after a chosen latency.
`timescale 1ns/10ps
module arsf_core_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Requests
    input wire logic go_in,
    input wire logic [3:0] lat_in,
    input wire logic [2:0] ch_in,
    input wire logic [9:0] data_in,
    // Core side
    output logic eoc_out,
    output logic [2:0] ch_out,
    output logic [9:0] data_out,
    output logic busy_out
);
    logic [3:0] cnt_q;
    // Outside a completion the lines carry the inverse, so stale values never match.
    assign eoc_out = busy_out && cnt_q == 4'h0;
    assign ch_out = eoc_out ? ch_in : ~ch_in;
    assign data_out = eoc_out ? data_in : ~data_in;
    always_ff @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in)
            {busy_out, cnt_q} <= 5'h00;
        else if (go_in)
            {busy_out, cnt_q} <= {1'b1, lat_in};
        else if (eoc_out)
            busy_out <= 1'b0;
        else if (busy_out)
            cnt_q <= cnt_q - 4'h1;
endmodule : arsf_core_model

// ===== verif/arsf_top_test.sv
// Self-checking bench for the converter result and status flag block.
`timescale 1ns/10ps
module arsf_top_test;
    import arsf_pkg::*;
    logic clk_in, arst_n_in, go_in, rd_ch_result_in, rd_last_result_in, rd_status_in;
    logic sleep_mode_in, eoc_in, conv_busy_in, global_result_ready_flag_out;
    logic general_overrun_flag_out, asleep_out;
    logic [3:0] lat_in;
    logic [2:0] ch_in, eoc_ch_in, rd_ch_sel_in, last_result_ch_out;
    logic [9:0] data_in, eoc_data_in, last_result_reg_out;
    logic [7:0] ch_enable_in, eoc_flag_out, channel_overrun_flag_out;
    logic [79:0] channel_result_register_out;
    wire logic [8:0] dn = {eoc_flag_out, global_result_ready_flag_out};
    wire logic [8:0] ov = {channel_overrun_flag_out, general_overrun_flag_out};
    int miscompares = 0;
    int n_compared = 0;
    arsf_top dut
    (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .eoc_in(eoc_in),
        .eoc_ch_in(eoc_ch_in),
        .eoc_data_in(eoc_data_in),
        .conv_busy_in(conv_busy_in),
        .ch_enable_in(ch_enable_in),
        .rd_ch_result_in(rd_ch_result_in),
        .rd_ch_sel_in(rd_ch_sel_in),
        .rd_last_result_in(rd_last_result_in),
        .rd_status_in(rd_status_in),
        .sleep_mode_in(sleep_mode_in),
        .channel_result_register_out(channel_result_register_out),
        .last_result_reg_out(last_result_reg_out),
        .last_result_ch_out(last_result_ch_out),
        .eoc_flag_out(eoc_flag_out),
        .channel_overrun_flag_out(channel_overrun_flag_out),
        .global_result_ready_flag_out(global_result_ready_flag_out),
        .general_overrun_flag_out(general_overrun_flag_out),
        .asleep_out(asleep_out)
    );
    arsf_core_model core
    (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .go_in(go_in),
        .lat_in(lat_in),
        .ch_in(ch_in),
        .data_in(data_in),
        .eoc_out(eoc_in),
        .ch_out(eoc_ch_in),
        .data_out(eoc_data_in),
        .busy_out(conv_busy_in)
    );
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task automatic pulse(input logic [2:0] ev);
        {rd_status_in, rd_last_result_in, rd_ch_result_in} = ev;
        @(posedge clk_in) #1;
        {rd_status_in, rd_last_result_in, rd_ch_result_in} = 3'h0;
        @(posedge clk_in) #1;
    endtask : pulse
    // Reads and enable changes land in the very cycle of the completion.
    task automatic conv(input logic [2:0] c, input logic [9:0] d, input logic [3:0] l,
        input logic [2:0] ev, input logic [7:0] en);
        int i;
        {ch_in, data_in, lat_in, go_in} = {c, d, l, 1'b1};
        @(posedge clk_in) #1;
        go_in = 1'b0;
        for (i = 0; i < 20 && eoc_in !== 1'b1; i++)
            @(posedge clk_in) #1;
        chk(eoc_in, 1'b1);
        if (eoc_in !== 1'b1)
            close_out();
        ch_enable_in = en;
        pulse(ev);
    endtask : conv
    initial
    begin
        {arst_n_in, go_in, rd_ch_result_in, rd_last_result_in, rd_status_in} = 5'h00;
        {sleep_mode_in, lat_in, ch_in, data_in, rd_ch_sel_in, ch_enable_in} = 29'h000000ff;
        repeat (2) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        conv(3'h2, 10'h155, 4'h3, 3'h0, 8'hff);
        chk({channel_result_register_out[29:20], last_result_reg_out}, {2{10'h155}});
        chk({last_result_ch_out, dn}, {3'h2, 8'h04, 1'b1});
        rd_ch_sel_in = 3'h5;
        conv(3'h3, 10'h2aa, 4'h0, 3'h1, 8'hff);
        chk(dn, {8'h0c, 1'b1});
        conv(3'h2, 10'h0f0, 4'h1, 3'h1, 8'hff);
        chk({ov, dn}, {8'h04, 1'b1, 8'h0c, 1'b1});
        rd_ch_sel_in = 3'h2;
        pulse(3'h1);
        chk(dn, {8'h08, 1'b1});
        conv(3'h2, 10'h001, 4'h1, 3'h4, 8'hff);
        chk(ov, 9'h001);
        conv(3'h2, 10'h3ff, 4'h0, 3'h4, 8'hff);
        chk(ov, {8'h04, 1'b1});
        pulse(3'h4);
        chk(ov, 9'h000);
        conv(3'h3, 10'h2c3, 4'h0, 3'h0, 8'hbf);
        chk(ov, {8'h08, 1'b1});
        chk({channel_result_register_out[39:30], last_result_reg_out}, {2{10'h2c3}});
        pulse(3'h2);
        chk(dn, {8'h04, 1'b0});
        conv(3'h1, 10'h111, 4'h0, 3'h4, 8'hbf);
        chk(ov, 9'h000);
        conv(3'h6, 10'h222, 4'h2, 3'h2, 8'hbf);
        chk({last_result_reg_out, dn[0]}, {10'h111, 1'b0});
        {ch_enable_in, rd_ch_sel_in} = {8'hff, 3'h5};
        conv(3'h7, 10'h333, 4'h3, 3'h1, 8'h7f);
        chk({eoc_flag_out[7], channel_result_register_out[79:70]}, 11'h000);
        sleep_mode_in = 1'b1;
        repeat (5) @(posedge clk_in);
        chk(asleep_out, 1'b0);
        conv(3'h0, 10'h0aa, 4'h2, 3'h0, 8'hff);
        chk(asleep_out, 1'b1);
        close_out();
    end
endmodule : arsf_top_test
bind arsf_top arsf_top_sva #(.NUM_CH(NUM_CH)) u_chk
(
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .eoc_in(eoc_in),
    .eoc_ch_in(eoc_ch_in),
    .conv_busy_in(conv_busy_in),
    .ch_enable_in(ch_enable_in),
    .rd_ch_result_in(rd_ch_result_in),
    .rd_ch_sel_in(rd_ch_sel_in),
    .rd_last_result_in(rd_last_result_in),
    .rd_status_in(rd_status_in),
    .eoc_flag_out(eoc_flag_out),
    .channel_overrun_flag_out(channel_overrun_flag_out),
    .global_result_ready_flag_out(global_result_ready_flag_out),
    .general_overrun_flag_out(general_overrun_flag_out)
);
